// >>> design/npecc_top.sv
// Page code block: peripheral bus registers, page sequencing and checking.
// Assumes the flash command, address and data strobes come from logic on
// clk_sys_i, one cycle each, and the page bus width is a steady level.
`timescale 1ns/100ps
module npecc_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Register bus
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  // Flash traffic
  input  wire logic        nand_wide_i,
  input  wire logic        nand_cmd_valid_i,
  input  wire logic [7:0]  nand_cmd_i,
  input  wire logic        nand_addr_valid_i,
  input  wire logic        nand_data_valid_i,
  input  wire logic [15:0] nand_data_i
);
  npecc_pkg::npecc_state_t state_reg;
  logic [1:0]  words_per_page_sel_reg;
  logic [2:0]  error_status_reg;
  logic [15:0] parity_result_reg;
  logic [15:0] inverse_parity_result_reg;
  logic        is_read_reg;
  logic        latch_wr_reg;
  logic [12:0] word_cnt_reg;
  logic [1:0]  code_cnt_reg;
  logic [31:0] code_reg;
  logic [31:0] prdata_reg;

  logic        wr_acc;
  logic        setup_rd;
  logic        sw_clear;
  logic        start_cmd;
  logic        main_word;
  logic        code_word;
  logic        code_last;
  logic [12:0] main_words;
  logic [31:0] code_full;
  logic [15:0] calc_p;
  logic [15:0] calc_n;
  logic [15:0] syn_p;
  logic [15:0] syn_n;
  logic [15:0] syn_or;
  logic [15:0] err_mask;
  logic        no_err;
  logic        data_err;
  logic        code_err;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign wr_acc   = psel_i & penable_i & pwrite_i;
  assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
  assign sw_clear = wr_acc & (paddr_i == npecc_pkg::OFS_CONTROL) &
                    pwdata_i[npecc_pkg::CTRL_RST_BIT];
  // start on read or write command
  assign start_cmd = nand_cmd_valid_i &
                     ((nand_cmd_i == npecc_pkg::CMD_READ) ||
                      (nand_cmd_i == npecc_pkg::CMD_WRITE));
  // main area size per select code
  assign main_words = npecc_pkg::MAIN_WORDS_BASE << words_per_page_sel_reg;
  assign main_word  = nand_data_valid_i & ~start_cmd & ~sw_clear &
                      ((state_reg == npecc_pkg::NPECC_ADDR) ||
                       (state_reg == npecc_pkg::NPECC_MAIN));
  assign code_word  = nand_data_valid_i & ~start_cmd & ~sw_clear &
                      (state_reg == npecc_pkg::NPECC_CODE);
  assign code_last  = code_word & (code_cnt_reg == (nand_wide_i ?
                      npecc_pkg::CODE_PIECES_16 : npecc_pkg::CODE_PIECES_8));
  assign code_full  = nand_wide_i ?
                      {nand_data_i, code_reg[31:16]} :
                      {nand_data_i[7:0], code_reg[31:8]};

  npecc_parity_engine u_engine (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .clear_i      (start_cmd | sw_clear),
    .word_valid_i (main_word),
    .wide_i       (nand_wide_i),
    .data_i       (nand_data_i),
    .index_i      (word_cnt_reg[11:0]),
    .par_o        (calc_p),
    .npar_o       (calc_n)
  );

  // ------------------------------------------------------------------
  // Check of stored code
  // ------------------------------------------------------------------
  assign syn_p    = calc_p ^ code_full[15:0];
  assign syn_n    = calc_n ^ code_full[31:16];
  assign syn_or   = syn_p | syn_n;
  assign err_mask = nand_wide_i ? npecc_pkg::DATA_ERR_MASK16 :
                                  npecc_pkg::DATA_ERR_MASK8;
  assign no_err   = (syn_or == 16'h0000);
  assign data_err = ((syn_p ^ syn_n) == err_mask);
  assign code_err = ~no_err & ((syn_or & (syn_or - 16'h0001)) == 16'h0000);

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= npecc_pkg::NPECC_IDLE;
    end else if (start_cmd) begin
      state_reg <= npecc_pkg::NPECC_CMD;
    end else if (sw_clear) begin
      state_reg <= npecc_pkg::NPECC_IDLE;
    end else begin
      unique case (state_reg)
        npecc_pkg::NPECC_IDLE: state_reg <= npecc_pkg::NPECC_IDLE;
        npecc_pkg::NPECC_CMD: begin
          if (nand_addr_valid_i) begin
            state_reg <= npecc_pkg::NPECC_ADDR;
          end
        end
        npecc_pkg::NPECC_ADDR, npecc_pkg::NPECC_MAIN: begin
          if (main_word && (word_cnt_reg == main_words - 13'h0001)) begin
            state_reg <= is_read_reg ? npecc_pkg::NPECC_CODE :
                                       npecc_pkg::NPECC_DONE;
          end else if (main_word) begin
            state_reg <= npecc_pkg::NPECC_MAIN;
          end
        end
        npecc_pkg::NPECC_CODE: begin
          if (code_last) begin
            state_reg <= npecc_pkg::NPECC_DONE;
          end
        end
        npecc_pkg::NPECC_DONE: state_reg <= npecc_pkg::NPECC_DONE;
        default:               state_reg <= npecc_pkg::NPECC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_cnt_reg <= 13'h0000;
      code_cnt_reg <= 2'h0;
      code_reg     <= 32'h0000_0000;
      is_read_reg  <= 1'b0;
    end else if (start_cmd) begin
      word_cnt_reg <= 13'h0000;
      code_cnt_reg <= 2'h0;
      is_read_reg  <= (nand_cmd_i == npecc_pkg::CMD_READ);
    end else if (main_word) begin
      word_cnt_reg <= word_cnt_reg + 13'h0001;
    end else if (code_word) begin
      code_cnt_reg <= code_cnt_reg + 2'h1;
      code_reg     <= code_full;
    end
  end

  // Engine sums land one edge after the last word, so writes latch late
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_wr_reg <= 1'b0;
    end else begin
      latch_wr_reg <= main_word & ~is_read_reg &
                      (word_cnt_reg == main_words - 13'h0001);
    end
  end

  // ------------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------------
  // load on write latch or last code piece first, else clear on command or software reset, else hold
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      error_status_reg          <= 3'h0;
      parity_result_reg         <= 16'h0000;
      inverse_parity_result_reg <= 16'h0000;
    end else if (latch_wr_reg) begin
      // A write result due in a clearing cycle still lands
      parity_result_reg         <= calc_p;
      inverse_parity_result_reg <= calc_n;
    end else if (code_last) begin
      error_status_reg[npecc_pkg::ST_DATA_BIT]  <= ~no_err & ~code_err;
      error_status_reg[npecc_pkg::ST_CODE_BIT]  <= code_err;
      error_status_reg[npecc_pkg::ST_MULTI_BIT] <= ~no_err & ~code_err &
                                                   ~data_err;
      parity_result_reg         <= syn_p;
      inverse_parity_result_reg <= syn_n;
    end else if (start_cmd || sw_clear) begin
      error_status_reg          <= 3'h0;
      parity_result_reg         <= 16'h0000;
      inverse_parity_result_reg <= 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  // page size select is read-write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      words_per_page_sel_reg <= npecc_pkg::RESET_VALUE[1:0];
    end else if (wr_acc && (paddr_i == npecc_pkg::OFS_MODE)) begin
      words_per_page_sel_reg <=
        pwdata_i[npecc_pkg::MODE_SIZE_LSB +: 2];
    end
  end

  // read decode, control and reserved read zero
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_reg <= npecc_pkg::RESET_VALUE;
    end else if (setup_rd) begin
      unique case (paddr_i)
        npecc_pkg::OFS_MODE:
          prdata_reg <= {30'h0000_0000, words_per_page_sel_reg};
        npecc_pkg::OFS_STATUS:
          prdata_reg <= {29'h0000_0000, error_status_reg};
        npecc_pkg::OFS_PARITY:
          prdata_reg <= {16'h0000, parity_result_reg};
        npecc_pkg::OFS_INVERSE_PARITY_BITS:
          prdata_reg <= {16'h0000, inverse_parity_result_reg};
        default:
          prdata_reg <= npecc_pkg::READ_ZERO;
      endcase
    end
  end
  assign prdata_o = prdata_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_read_setup(logic [7:0] ofs);
    psel_i && !penable_i && !pwrite_i && paddr_i == ofs;
  endsequence

  reserved_read_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i > npecc_pkg::OFS_INVERSE_PARITY_BITS)
    |=> prdata_o == 32'h0000_0000)
    else $error("reserved offset read nonzero");

  control_read_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    s_read_setup(npecc_pkg::OFS_CONTROL) |=> prdata_o == 32'h0000_0000)
    else $error("control register read nonzero");

  mode_readback_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (wr_acc && paddr_i == npecc_pkg::OFS_MODE) ##2
    s_read_setup(npecc_pkg::OFS_MODE)
    |=> prdata_o[1:0] == $past(pwdata_i[1:0], 3))
    else $error("page size readback wrong");

  cmd_clears_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (start_cmd && !code_last && !latch_wr_reg) |=>
    error_status_reg == 3'h0 && parity_result_reg == 16'h0000)
    else $error("command did not clear results");

  sw_clear_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (sw_clear && !code_last && !latch_wr_reg) |=>
    parity_result_reg == 16'h0000 && inverse_parity_result_reg == 16'h0000)
    else $error("software clear missed");

  write_latch_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (main_word && !is_read_reg && word_cnt_reg == main_words - 13'h0001)
    |=> ##1 parity_result_reg == $past(calc_p))
    else $error("write parity not latched");

  result_lock_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    (state_reg == npecc_pkg::NPECC_DONE && !latch_wr_reg &&
     !start_cmd && !sw_clear) |=> $stable(parity_result_reg))
    else $error("locked result changed");

  multi_flags_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    error_status_reg[npecc_pkg::ST_MULTI_BIT] |->
    error_status_reg[npecc_pkg::ST_DATA_BIT])
    else $error("multi error without error flag");

  code_err_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    $rose(error_status_reg[npecc_pkg::ST_CODE_BIT]) |->
    $onehot(parity_result_reg | inverse_parity_result_reg))
    else $error("code error position not single");

  main_count_a: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    start_cmd |=> word_cnt_reg == 13'h0000)
    else $error("word count not restarted");
endmodule

// >>> design/npecc_pkg.sv
// Constants shared by the page code block: offsets, fields, resets, counts.
// Assumes the register bus is the peripheral bus with 32-bit data.
package npecc_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_MODE        = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_PARITY      = 8'h0C;
  localparam logic [7:0]  OFS_INVERSE_PARITY_BITS     = 8'h10;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
  // ------------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------------
  localparam int          CTRL_RST_BIT    = 0;
  localparam int          MODE_SIZE_LSB   = 0;
  localparam int          ST_DATA_BIT     = 0;
  localparam int          ST_CODE_BIT     = 1;
  localparam int          ST_MULTI_BIT    = 2;
  localparam int          BIT_OFS_LSB     = 0;
  localparam int          WORD_IDX_LSB    = 4;
  // ------------------------------------------------------------------
  // Flash commands and page geometry
  // ------------------------------------------------------------------
  localparam logic [7:0]  CMD_READ        = 8'h00;
  localparam logic [7:0]  CMD_WRITE       = 8'h80;
  localparam logic [12:0] MAIN_WORDS_BASE = 13'h0200;
  localparam logic [1:0]  CODE_PIECES_8   = 2'h3;
  localparam logic [1:0]  CODE_PIECES_16  = 2'h1;
  localparam logic [15:0] DATA_ERR_MASK16 = 16'hFFFF;
  localparam logic [15:0] DATA_ERR_MASK8  = 16'hFFF7;

  typedef enum logic [2:0] {
    NPECC_IDLE = 3'b000,
    NPECC_CMD  = 3'b001,
    NPECC_ADDR = 3'b010,
    NPECC_MAIN = 3'b011,
    NPECC_CODE = 3'b100,
    NPECC_DONE = 3'b101
  } npecc_state_t;
endpackage

// >>> design/npecc_parity_engine.sv
// Accumulates line and column parity over the words of a page main area.
// Assumes words arrive on clk_sys_i as one-cycle strobes with their index.
`timescale 1ns/100ps
module npecc_parity_engine (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Control
  input  wire logic        clear_i,
  input  wire logic        word_valid_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] data_i,
  input  wire logic [11:0] index_i,
  // Results
  output logic      [15:0] par_o,
  output logic      [15:0] npar_o
);
  localparam logic [15:0] COL_MASK [4] = '{16'hAAAA, 16'hCCCC,
                                           16'hF0F0, 16'hFF00};
  logic [15:0] data_m;
  logic        word_par;
  logic [15:0] term_p;
  logic [15:0] term_n;

  assign data_m   = wide_i ? data_i : {8'h00, data_i[7:0]};
  assign word_par = ^data_m;

  for (genvar b = 0; b < 4; b++) begin : g_col
    if (b == 3) begin : g_hi
      assign term_p[b] = wide_i & (^(data_m & COL_MASK[b]));
      assign term_n[b] = wide_i & (^(data_m & ~COL_MASK[b]));
    end else begin : g_lo
      assign term_p[b] = ^(data_m & COL_MASK[b]);
      assign term_n[b] = ^(data_m & ~COL_MASK[b]);
    end
  end
  for (genvar i = 0; i < 12; i++) begin : g_line
    assign term_p[i+4] = word_par & index_i[i];
    assign term_n[i+4] = word_par & ~index_i[i];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      par_o  <= 16'h0000;
      npar_o <= 16'h0000;
    end else if (clear_i) begin
      par_o  <= 16'h0000;
      npar_o <= 16'h0000;
    end else if (word_valid_i) begin
      par_o  <= par_o ^ term_p;
      npar_o <= npar_o ^ term_n;
    end
  end
endmodule

// >>> tb/npecc_flash_model.sv
// Flash side model: command, address cycle, page words, stored code.
// Assumes one clock shared with the page code block; drives after edges.
`timescale 1ns/100ps
module npecc_flash_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Flash traffic
  output logic             nand_wide_o,
  output logic             nand_cmd_valid_o,
  output logic      [7:0]  nand_cmd_o,
  output logic             nand_addr_valid_o,
  output logic             nand_data_valid_o,
  output logic      [15:0] nand_data_o
);
  logic [15:0] mem [0:4095];

  initial begin
    nand_wide_o       = 1'b1;
    nand_cmd_valid_o  = 1'b0;
    nand_cmd_o        = 8'h00;
    nand_addr_valid_o = 1'b0;
    nand_data_valid_o = 1'b0;
    nand_data_o       = 16'h0000;
  end

  // ------------------------------------------------------------------
  // Page transfer
  // ------------------------------------------------------------------
  // Two spare words follow the code so that locked results are probed
  task automatic xfer(input logic [7:0] cmd, input logic wide,
                      input int nw, input int np, input logic [31:0] code);
    logic [15:0] w;
    @(posedge clk_sys_i);
    nand_wide_o      <= wide;
    nand_cmd_valid_o <= 1'b1;
    nand_cmd_o       <= cmd;
    @(posedge clk_sys_i);
    nand_cmd_valid_o  <= 1'b0;
    nand_cmd_o        <= ~cmd;
    nand_addr_valid_o <= 1'b1;
    for (int i = 0; i < nw + np + 2; i++) begin
      w = 16'h5A00 ^ i[15:0];
      if (i < nw)
        w = mem[i];
      if (i >= nw && i < nw + np)
        w = wide ? code[16*(i-nw) +: 16] : {2{code[8*(i-nw) +: 8]}};
      @(posedge clk_sys_i);
      nand_addr_valid_o <= 1'b0;
      nand_data_valid_o <= 1'b1;
      nand_data_o       <= w;
    end
    @(posedge clk_sys_i);
    nand_data_valid_o <= 1'b0;
    nand_data_o       <= ~w;
  endtask
endmodule

// >>> tb/npecc_top_tb_top.sv
// Self-checking bench for the page code block with a flash side model.
// Assumes the design answers register reads without wait states.
`timescale 1ns/100ps
module npecc_top_tb_top;
  localparam int LIMIT = 20000;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        wide;
  logic        cmd_v;
  logic [7:0]  cmd;
  logic        addr_v;
  logic        data_v;
  logic [15:0] data;
  logic [31:0] c;
  int          seed = 30;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  npecc_top npecc_top_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .nand_wide_i(wide),
    .nand_cmd_valid_i(cmd_v), .nand_cmd_i(cmd),
    .nand_addr_valid_i(addr_v), .nand_data_valid_i(data_v),
    .nand_data_i(data)
  );
  npecc_flash_model npecc_flash_model_i (
    .clk_sys_i(clk_sys_i), .nand_wide_o(wide), .nand_cmd_valid_o(cmd_v),
    .nand_cmd_o(cmd), .nand_addr_valid_o(addr_v),
    .nand_data_valid_o(data_v), .nand_data_o(data)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    q = prdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    logic [31:0] q;
    apb(a, 1'b0, 32'h0000_0000, q);
    check(nm, e, q);
  endtask

  task automatic fill();
    for (int i = 0; i < 4096; i++)
      npecc_flash_model_i.mem[i] = $random(seed);
  endtask

  // Syndrome layout: low 4 bits are the bit offset, upper 12 the index
  function automatic logic [31:0] code_of(input int n, input logic w);
    logic [15:0] p;
    logic [15:0] q;
    logic [15:0] pos;
    p = 16'h0000;
    q = 16'h0000;
    for (int i = 0; i < n; i++)
      for (int b = 0; b < 16; b++)
        if ((w || b < 8) && npecc_flash_model_i.mem[i][b]) begin
          pos = {i[11:0], b[3:0]};
          p = p ^ pos;
          q = q ^ ~pos;
        end
    q = q & (w ? npecc_pkg::DATA_ERR_MASK16 : npecc_pkg::DATA_ERR_MASK8);
    return {q, p};
  endfunction

  // Kinds: 0 clean, 1 one data bit, 2 one code bit, 3 two data bits
  task automatic read_case(input int kind, input logic w);
    logic [31:0] sc;
    logic [15:0] pos;
    int          wi;
    int          bi;
    fill();
    sc = code_of(512, w);
    wi = {$random(seed)} % 512;
    bi = {$random(seed)} % (w ? 16 : 8);
    pos = {wi[11:0], bi[3:0]};
    if (kind == 1 || kind == 3)
      npecc_flash_model_i.mem[wi][bi] = ~npecc_flash_model_i.mem[wi][bi];
    if (kind == 3)
      npecc_flash_model_i.mem[(wi+7)%512][bi] =
        ~npecc_flash_model_i.mem[(wi+7)%512][bi];
    if (kind == 2)
      sc[bi] = ~sc[bi];
    npecc_flash_model_i.xfer(npecc_pkg::CMD_READ, w, 512, w ? 2 : 4, sc);
    repeat (3) @(posedge clk_sys_i);
    rdchk(npecc_pkg::OFS_STATUS, {29'h0, kind == 3, kind == 2,
          kind == 1 || kind == 3}, "status");
    if (kind == 0)
      rdchk(npecc_pkg::OFS_PARITY, 32'h0000_0000, "clean parity");
    if (kind == 1) begin
      rdchk(npecc_pkg::OFS_PARITY, {16'h0, pos}, "bad position");
      rdchk(npecc_pkg::OFS_INVERSE_PARITY_BITS, {16'h0, ~pos & (w ?
            npecc_pkg::DATA_ERR_MASK16 : npecc_pkg::DATA_ERR_MASK8)},
            "inverse position");
    end
    if (kind == 2) begin
      apb(npecc_pkg::OFS_PARITY, 1'b0, 32'h0, sc);
      apb(npecc_pkg::OFS_INVERSE_PARITY_BITS, 1'b0, 32'h0, c);
      check("code bit", 32'h1 << bi, sc | c);
    end
  endtask

  // ------------------------------------------------------------------
  // Clock, reset, timeout and scenarios
  // ------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    resetn_i  = 1'b0;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0000_0000;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int a = 0; a <= 8'h14; a += 4)
      rdchk(a[7:0], 32'h0000_0000, "reset value");
    rdchk(8'hFC, 32'h0000_0000, "reserved top");
    wr(8'h14, 32'hFFFF_FFFF);
    wr(npecc_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'h0000_0000, "reserved after write");
    rdchk(npecc_pkg::OFS_STATUS, 32'h0000_0000, "status written");
    rdchk(npecc_pkg::OFS_MODE, 32'h0000_0000, "mode kept");
    for (int s = 0; s < 4; s++) begin
      wr(npecc_pkg::OFS_MODE, s);
      rdchk(npecc_pkg::OFS_MODE, s, "page size mode");
      fill();
      npecc_flash_model_i.xfer(npecc_pkg::CMD_WRITE, s[0], 512 << s, 0,
                               32'h0000_0000);
      repeat (3) @(posedge clk_sys_i);
      c = code_of(512 << s, s[0]);
      rdchk(npecc_pkg::OFS_PARITY, {16'h0, c[15:0]},
            "write parity");
      rdchk(npecc_pkg::OFS_INVERSE_PARITY_BITS, {16'h0, c[31:16]},
            "write inverse");
    end
    wr(npecc_pkg::OFS_PARITY, 32'hFFFF_FFFF);
    rdchk(npecc_pkg::OFS_PARITY, {16'h0, c[15:0]}, "parity kept");
    wr(npecc_pkg::OFS_CONTROL, 32'h0000_0000);
    rdchk(npecc_pkg::OFS_INVERSE_PARITY_BITS, {16'h0, c[31:16]}, "zero clear");
    wr(npecc_pkg::OFS_CONTROL, 32'h0000_0001);
    rdchk(npecc_pkg::OFS_PARITY, 32'h0000_0000, "cleared parity");
    rdchk(npecc_pkg::OFS_INVERSE_PARITY_BITS, 32'h0000_0000, "cleared inverse");
    wr(npecc_pkg::OFS_MODE, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
      read_case(k, 1'b1);
    npecc_flash_model_i.xfer(npecc_pkg::CMD_WRITE, 1'b1, 512, 0, 32'h0);
    rdchk(npecc_pkg::OFS_STATUS, 32'h0000_0000, "status on command");
    read_case(1, 1'b0);
    final_report();
  end
endmodule
